/* read_cycle_seq.sv */
// Bus-master read sequencer: single, quadword and octaword read cycles.
// Assumes responder inputs are synchronous to mclk_in and bus wires are resolved outside.
`timescale 1ns/1ns
module read_cycle_seq
  import rd_cycle_pkg::*;
(
  input  wire logic        mclk_in,                      // Input clock
  input  wire logic        reset_n_in,                   // Async reset, active low
  input  wire logic        req_valid_in,                 // Read request
  output logic             req_ready_out,                // Request taken this cycle
  input  wire logic [1:0]  req_len_in,                   // Length code
  input  wire logic [27:0] req_addr_in,                  // Longword address 29:02
  input  wire logic [15:0] req_bm_in,                    // Byte masks, 4 per longword
  input  wire logic [4:0]  req_status_in,                // Cycle status code
  input  wire logic        req_demand_in,                // Demand read
  input  wire logic        req_prefetch_in,              // Prefetch reference
  input  wire logic        req_coproc_in,                // Network coprocessor initiator
  output logic [31:0]      rd_data_out,                  // Read longword
  output logic             rd_data_valid_out,            // Data pulse
  output logic [1:0]       rd_word_idx_out,              // Longword index in block
  output logic             done_out,                     // Cycle finished pulse
  output logic             mcheck_out,                   // Machine check pulse
  output logic             coproc_irq_out,               // Processor interrupt pulse
  output logic             cache_fill_out,               // Fill cache entry pulse
  output logic             cache_inval_out,              // Invalidate entry pulse
  output logic             retry_out,                    // Reissue request pulse
  output logic [7:0]       memory_error_log_register_out, // Error log
  input  wire logic        log_clear_in,                 // Clear error log
  output logic [31:0]      muxed_addr_data_lines_out,    // Bus lines out
  output logic             muxed_addr_data_lines_oe_n_out, // Bus drive, low drives
  input  wire logic [31:0] muxed_addr_data_lines_in,     // Bus lines in
  output logic [4:0]       cycle_status_parity_lines_n_out, // Status/parity out
  output logic             cycle_status_parity_lines_oe_n_out, // Low drives
  input  wire logic [4:0]  cycle_status_parity_lines_n_in, // Status/parity in
  output logic [3:0]       byte_mask_lines_n_out,        // Byte masks
  output logic             wr_n_out,                     // Write direction
  output logic             addr_valid_strobe_n_out,      // Address strobe
  output logic             data_strobe_signal_n_out,     // Data strobe
  input  wire logic        rdy_n_in,                     // Ready response
  input  wire logic        err_n_in,                     // Fault response
  input  wire logic        parity_check_enable_n_in,     // Check parity
  input  wire logic        cache_inhibit_response_n_in   // Cache inhibit
);
  typedef struct packed {
    cyc_state_t  st;
    logic [1:0]  len;
    logic [27:0] addr;
    logic [15:0] bm;
    logic [4:0]  status;
    logic        demand;
    logic        prefetch;
    logic        coproc;
    logic [1:0]  word;
    logic [3:0]  uc_cnt;
    logic        first;
    logic        slip;
    logic        err_seen;
    logic        par_bad;
    logic [31:0] data;
    logic        data_vld;
    logic [1:0]  data_idx;
    logic        done;
    logic        mcheck;
    logic        irq;
    logic        fill;
    logic        inval;
    logic        retry;
    logic [7:0]  log;
  } seq_state_t;

  seq_state_t q_ff, nxt_q;
  tick_if     tk ();
  logic       par_err;
  logic       tick, rdy, err, cctl, samp;

  phase_gen u_phase (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .tk         (tk)
  );

  parity_chk u_par (
    .data_in     (muxed_addr_data_lines_in),
    .par_in      (~cycle_status_parity_lines_n_in[3:0]),
    .check_in    (!parity_check_enable_n_in),
    .par_err_out (par_err)
  );

  function automatic logic [3:0] min_uc(input logic [1:0] len);
    case (len)
      LEN_QUAD: min_uc = MIN_UC_QUAD;
      LEN_OCTA: min_uc = MIN_UC_OCTA;
      default:  min_uc = MIN_UC_LONG;
    endcase
  endfunction

  function automatic logic may_retry(input logic pf, input logic cp);
    may_retry = !pf && !cp;
  endfunction

  assign tick = tk.p1_tick;
  assign rdy  = !rdy_n_in;
  assign err  = !err_n_in;
  assign cctl = !cache_inhibit_response_n_in;
  // Single reads sample every clock once the first phase has passed
  assign samp = (q_ff.st == ST_DATA) && !q_ff.slip &&
                (tick || (q_ff.len == LEN_LONG && !q_ff.first)); // [RULE5] [RULE13] [RULE20]

  always_comb begin
    logic fin;
    logic nxt_word;
    logic set_par;
    logic set_bus;
    fin      = 1'b0;
    nxt_word = 1'b0;
    set_par  = 1'b0;
    set_bus  = 1'b0;
    nxt_q    = q_ff;
    {nxt_q.data_vld, nxt_q.done, nxt_q.mcheck, nxt_q.irq} = '0;
    {nxt_q.fill, nxt_q.inval, nxt_q.retry} = '0;
    if (log_clear_in) begin
      nxt_q.log = '0;
    end
    if (tick && q_ff.st != ST_IDLE && q_ff.uc_cnt != 4'hF) begin
      nxt_q.uc_cnt = q_ff.uc_cnt + 4'h1;
    end
    case (q_ff.st)
      ST_IDLE: begin
        if (req_valid_in && tick) begin
          nxt_q.st       = ST_ADDR;
          nxt_q.len      = req_len_in; // [RULE3]
          nxt_q.addr     = req_addr_in; // [RULE12]
          nxt_q.bm       = req_bm_in;
          nxt_q.status   = req_status_in;
          nxt_q.demand   = req_demand_in;
          nxt_q.prefetch = req_prefetch_in;
          nxt_q.coproc   = req_coproc_in;
          nxt_q.word     = '0;
          nxt_q.uc_cnt   = '0;
          nxt_q.err_seen = 1'b0;
          nxt_q.par_bad  = 1'b0;
          if (req_len_in == LEN_OCTA) begin
            nxt_q.addr[1:0] = 2'h0; // [RULE19]
            nxt_q.status    = req_status_in | OCTA_STS_SET; // [RULE19]
          end
        end
      end
      ST_ADDR: begin
        if (tick) begin
          nxt_q.st    = ST_DATA;
          nxt_q.first = 1'b1;
          nxt_q.slip  = (q_ff.len == LEN_OCTA); // [RULE20]
        end
      end
      ST_DATA: begin
        if (tick) begin
          nxt_q.first = 1'b0;
          nxt_q.slip  = 1'b0;
          // Fault must persist across two consecutive first-phase samples
          nxt_q.err_seen = samp && err && !rdy; // [RULE8]
        end
        if (samp && rdy && !err) begin
          case (q_ff.len)
            LEN_QUAD: begin
              if (q_ff.word == 2'h0) begin
                if (par_err) begin
                  set_par       = 1'b1;
                  nxt_q.par_bad = 1'b1; // [RULE15]
                  nxt_q.mcheck  = q_ff.demand;
                  nxt_word      = 1'b1;
                end else if (cctl) begin
                  nxt_q.data_vld = 1'b1;
                  nxt_q.inval    = 1'b1; // [RULE14]
                  fin            = 1'b1;
                end else begin
                  nxt_q.data_vld = 1'b1;
                  nxt_word       = 1'b1; // [RULE11]
                end
              end else begin
                set_par        = par_err;
                nxt_q.data_vld = !par_err && !q_ff.par_bad; // [RULE15]
                nxt_q.fill     = !par_err && !q_ff.par_bad;
                nxt_q.inval    = par_err || q_ff.par_bad;
                fin            = 1'b1;
              end
            end
            LEN_OCTA: begin
              if (par_err) begin
                nxt_q.irq = 1'b1; // [RULE21]
                fin       = 1'b1;
              end else begin
                nxt_q.data_vld = 1'b1;
                fin            = (q_ff.word == LAST_OCTA_WD); // [RULE18]
                nxt_word       = (q_ff.word != LAST_OCTA_WD);
              end
            end
            default: begin
              set_par        = par_err; // [RULE7]
              nxt_q.mcheck   = par_err && q_ff.demand;
              nxt_q.data_vld = !par_err;
              fin            = 1'b1;
            end
          endcase
        end else if (samp && rdy && err) begin
          fin = 1'b1;
          case (q_ff.len)
            LEN_QUAD: begin
              nxt_q.retry = (q_ff.word == 2'h0) && may_retry(q_ff.prefetch, q_ff.coproc);
              nxt_q.inval = (q_ff.word != 2'h0); // [RULE17]
            end
            LEN_OCTA: nxt_q.retry = 1'b0; // [RULE22]
            default:  nxt_q.retry = may_retry(q_ff.prefetch, q_ff.coproc); // [RULE9]
          endcase
        end else if (samp && tick && err && !rdy && q_ff.err_seen) begin
          set_bus      = 1'b1; // [RULE8]
          fin          = 1'b1;
          nxt_q.mcheck = q_ff.demand && (q_ff.len == LEN_LONG ||
                         (q_ff.len == LEN_QUAD && q_ff.word == 2'h0)); // [RULE16]
          nxt_q.inval  = (q_ff.len == LEN_QUAD); // [RULE16]
        end
        if (fin) begin
          nxt_q.st       = ST_END;
          nxt_q.err_seen = 1'b0;
        end else if (nxt_word) begin
          nxt_q.st       = ST_GAP; // [RULE13]
          nxt_q.word     = q_ff.word + 2'h1;
          nxt_q.err_seen = 1'b0;
        end
      end
      ST_GAP: begin
        nxt_q.st    = ST_DATA;
        nxt_q.first = 1'b1;
      end
      ST_END: begin
        // Address strobe holds until the minimum cycle length is reached
        if (tick && q_ff.uc_cnt >= min_uc(q_ff.len)) begin // [RULE2] [RULE11] [RULE18]
          nxt_q.st   = ST_IDLE;
          nxt_q.done = 1'b1;
        end
      end
      default: nxt_q.st = ST_IDLE;
    endcase
    if (nxt_q.data_vld) begin
      nxt_q.data     = muxed_addr_data_lines_in;
      nxt_q.data_idx = (q_ff.len == LEN_QUAD) ? {1'b0, q_ff.addr[0] ^ q_ff.word[0]} : q_ff.word;
    end
    // Setting beats a clear in the same cycle
    if (set_par || set_bus) begin
      nxt_q.log[LOG_PAR_BIT]                = set_par; // [RULE7]
      nxt_q.log[LOG_BUS_BIT]                = set_bus;
      nxt_q.log[LOG_WORD_LSB +: 2]          = q_ff.word;
      nxt_q.log[LOG_LEN_LSB +: 2]           = q_ff.len;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_ff    <= '0;
      q_ff.st <= ST_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign req_ready_out                      = (q_ff.st == ST_IDLE) && tick;
  assign rd_data_out                        = q_ff.data;
  assign rd_data_valid_out                  = q_ff.data_vld;
  assign rd_word_idx_out                    = q_ff.data_idx;
  assign done_out                           = q_ff.done;
  assign mcheck_out                         = q_ff.mcheck;
  assign coproc_irq_out                     = q_ff.irq;
  assign cache_fill_out                     = q_ff.fill;
  assign cache_inval_out                    = q_ff.inval;
  assign retry_out                          = q_ff.retry;
  assign memory_error_log_register_out      = q_ff.log;
  assign muxed_addr_data_lines_out          = {q_ff.len, q_ff.addr, 2'h0}; // [RULE3]
  assign muxed_addr_data_lines_oe_n_out     = (q_ff.st != ST_ADDR);
  assign cycle_status_parity_lines_n_out    = q_ff.status;
  assign cycle_status_parity_lines_oe_n_out = (q_ff.st != ST_ADDR); // [RULE4]
  assign byte_mask_lines_n_out              = ~q_ff.bm[q_ff.word*4 +: 4]; // [RULE20]
  assign wr_n_out                           = 1'b1; // [RULE4]
  // Address strobe falls mid address phase so lines are still driven
  assign addr_valid_strobe_n_out  = !((q_ff.st == ST_ADDR && tick) || q_ff.st == ST_DATA ||
                                      q_ff.st == ST_GAP || q_ff.st == ST_END); // [RULE4]
  assign data_strobe_signal_n_out = (q_ff.st != ST_DATA); // [RULE10] [RULE13]

  ds_inside_as_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !data_strobe_signal_n_out |-> !addr_valid_strobe_n_out) else $error("data strobe w/o addr"); // [RULE4]
  len_code_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !muxed_addr_data_lines_oe_n_out |-> muxed_addr_data_lines_out[31:30] == q_ff.len &&
    q_ff.len != 2'h0) else $error("bad length code"); // [RULE3]
  octa_align_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (!muxed_addr_data_lines_oe_n_out && q_ff.len == LEN_OCTA) |->
    muxed_addr_data_lines_out[3:2] == 2'h0 &&
    (cycle_status_parity_lines_n_out & OCTA_STS_SET) == OCTA_STS_SET)
    else $error("octaword not aligned"); // [RULE19]
  mcheck_demand_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    mcheck_out |-> q_ff.demand && q_ff.len != LEN_OCTA) else $error("bad machine check"); // [RULE7]
  octa_no_retry_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    retry_out |-> q_ff.len != LEN_OCTA && !q_ff.coproc && !q_ff.prefetch)
    else $error("illegal retry"); // [RULE9]
  strobes_released_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done_out |-> addr_valid_strobe_n_out && data_strobe_signal_n_out)
    else $error("strobes held after end"); // [RULE10]
  cctl_ends_quad_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (samp && rdy && !err && !par_err && cctl && q_ff.len == LEN_QUAD && q_ff.word == 2'h0)
    |=> cache_inval_out && !cache_fill_out ##1 data_strobe_signal_n_out[*2])
    else $error("cache inhibit ignored"); // [RULE14]
  bus_err_two_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (samp && tick && err && !rdy && !q_ff.err_seen) |=> q_ff.st == ST_DATA)
    else $error("bus error taken on one sample"); // [RULE8]
  single_min_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (req_ready_out && req_valid_in && req_len_in == LEN_LONG) |=> !done_out[*4])
    else $error("single read too short"); // [RULE2]
  octa_slip_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(q_ff.slip) |-> !samp[*2]) else $error("octaword sampled without slip"); // [RULE20]

  single_ok_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_data_valid_out && q_ff.len == LEN_LONG);
  quad_fill_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in) cache_fill_out);
  octa_done_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    done_out && q_ff.len == LEN_OCTA && rd_word_idx_out == LAST_OCTA_WD);
  retry_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in) retry_out);
endmodule

/* rd_cycle_pkg.sv */
// Constants, codes and state type of the bus-master read cycle sequencer.
// Assumes one 10 MHz clock; two clock cycles form one bus microcycle.
// Summary of operation
// RULE1 - A microcycle is four phases, equal to two input clock periods.
// RULE2 - Single longword read lasts two microcycles or more, stretched in whole microcycles.
// RULE3 - Address on bits 29:02; bits 31:30 give length 01, 10 or 11.
// RULE4 - Drive byte masks and status, write line negated, then address strobe, then data strobe.
// RULE5 - Single read samples completion every two phases from the next first phase.
// RULE6 - Responder returns data, parity, parity enable and ready without fault.
// RULE7 - Checked parity error on single read: log, discard, machine check if demand.
// RULE8 - Fault without ready is a bus error once seen at two first-phase samples.
// RULE9 - Ready with fault means retry; never reissue prefetch or coprocessor cycles.
// RULE10 - Every read ends by releasing data strobe and address strobe.
// RULE11 - Quadword read fetches two longwords in three microcycles or more.
// RULE12 - Quadword sends preferred address only; responder inverts bit 02 for the second.
// RULE13 - Quadword pulses data strobe per longword, samples every microcycle from next first phase.
// RULE14 - Cache inhibit on first quadword longword ends the cycle and invalidates the entry.
// RULE15 - Parity error on first quadword longword: still fetch second, discard, log, invalidate.
// RULE16 - Bus error on either quadword longword ends cycle; only first may machine check.
// RULE17 - Retry on first quadword longword leaves cache; on second invalidates, no reissue.
// RULE18 - Octaword read fetches four longwords, coprocessor only, nine microcycles or more. The code accepts it from any initiator.
// RULE19 - Octaword address aligned with bits 03:02 zero, status 1X111; responder counts up.
// RULE20 - Octaword updates byte masks per data strobe, slips one microcycle before sampling.
// RULE21 - Octaword parity error interrupts and aborts; bus error aborts after current longword.
// RULE22 - Octaword is never retried; ready with fault finishes the longword and aborts.
package rd_cycle_pkg;
  localparam int          CLKS_PER_UC   = 2;
  localparam int          PHASES_PER_UC = 4;
  localparam logic [1:0]  LEN_LONG      = 2'h1;
  localparam logic [1:0]  LEN_QUAD      = 2'h2;
  localparam logic [1:0]  LEN_OCTA      = 2'h3;
  localparam logic [3:0]  MIN_UC_LONG   = 4'h2;
  localparam logic [3:0]  MIN_UC_QUAD   = 4'h3;
  localparam logic [3:0]  MIN_UC_OCTA   = 4'h9;
  localparam logic [4:0]  OCTA_STS_SET  = 5'h17;
  localparam logic [1:0]  LAST_OCTA_WD  = 2'h3;
  localparam logic        PARITY_ODD    = 1'b1;
  localparam int          LOG_PAR_BIT   = 0;
  localparam int          LOG_BUS_BIT   = 1;
  localparam int          LOG_WORD_LSB  = 2;
  localparam int          LOG_LEN_LSB   = 4;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_GAP, ST_END} cyc_state_t;
endpackage

/* tick_if.sv */
// Microcycle timing carrier between the phase divider and the sequencer.
// Assumes both ends share mclk_in.
`timescale 1ns/1ns
interface tick_if;
  logic       p1_tick;
  logic [1:0] phase;
  modport src (output p1_tick, output phase);
  modport snk (input  p1_tick, input  phase);
endinterface

/* phase_gen.sv */
// Phase divider: one first-phase enable pulse per microcycle.
// Assumes mclk_in is the input clock; each clock period spans two phases.
`timescale 1ns/1ns
module phase_gen
  import rd_cycle_pkg::*;
(
  input  wire logic mclk_in,    // Input clock
  input  wire logic reset_n_in, // Async reset, active low
  tick_if.src       tk          // Phase enables out
);
  typedef struct packed {
    logic [0:0] cnt;
  } ph_state_t;
  ph_state_t q_ff, nxt_q;

  always_comb begin
    nxt_q     = q_ff;
    nxt_q.cnt = q_ff.cnt + 1'b1; // [RULE1]
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Two phases elapse per clock, four per microcycle
  assign tk.p1_tick = (q_ff.cnt == 1'b0);
  assign tk.phase   = {q_ff.cnt, 1'b0};

  p1_period_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    tk.p1_tick |=> !tk.p1_tick ##1 tk.p1_tick) else $error("first phase not every 2 clocks"); // [RULE1]
endmodule

/* parity_chk.sv */
// Byte parity checker for read data and the four returned parity bits.
// Assumes parity bits are already converted to active-high sense.
`timescale 1ns/1ns
module parity_chk
  import rd_cycle_pkg::*;
(
  input  wire logic [31:0] data_in,   // Read data
  input  wire logic [3:0]  par_in,    // Byte parity bits
  input  wire logic        check_in,  // Parity check enabled
  output logic             par_err_out // Checked parity mismatch
);
  function automatic logic byte_bad(input logic [7:0] b, input logic p);
    byte_bad = ((^b) ^ p) != PARITY_ODD;
  endfunction

  logic [3:0] bad;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bad[i] = byte_bad(data_in[i*8 +: 8], par_in[i]);
    end
    par_err_out = check_in && (|bad); // [RULE7]
  end
endmodule

/* resp_model.sv */
// Responder model: answers each data strobe with data, parity and a completion code.
// Assumes the bench sets mode, failing word and delay before each request.
`timescale 1ns/1ns
module resp_model
  import rd_cycle_pkg::*;
(
  input  wire logic        clk_in,   // Input clock
  input  wire logic        oe_n_in,  // Master drives address
  input  wire logic [31:0] dal_in,   // Resolved lines
  input  wire logic        ds_n_in,  // Data strobe
  input  wire logic [2:0]  mode_in,  // 0 ok 1 par 2 bus 3 retry 4 inhibit 5 unchecked
  input  wire logic [1:0]  bad_in,   // Word given the mode
  input  wire logic [1:0]  dly_in,   // Answer delay
  output logic      [31:0] dal_out,  // Read data
  output logic      [4:0]  cs_n_out, // Parity
  output logic      [3:0]  rsp_n_out // Ready, fault, check, inhibit
);
  logic [27:0] base = 28'h0;
  logic [27:0] wa;
  logic [1:0]  len = 2'h0;
  logic [1:0]  w = 2'h0;
  logic [1:0]  cnt = 2'h0;
  logic        act = 1'b0;
  logic        hit;
  function automatic logic [3:0] par(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction
  initial {dal_out, cs_n_out, rsp_n_out} = {32'h0, 5'h1F, 4'hF};
  always @(posedge clk_in) begin
    if (!oe_n_in) begin
      base <= dal_in[29:2];
      len  <= dal_in[31:30];
      w    <= 2'h0;
    end
    if (ds_n_in) begin
      // Released: pulled-up strobes, churning lines so stale data never matches
      if (act) w <= w + 2'h1;
      act       <= 1'b0;
      cnt       <= 2'h0;
      rsp_n_out <= 4'hF;
      dal_out   <= ~dal_out;
      cs_n_out  <= ~cs_n_out;
    end else if (!act && cnt != dly_in) begin
      cnt <= cnt + 2'h1;
    end else if (!act) begin
      hit = w == bad_in;
      wa  = (len == LEN_QUAD) ? base ^ {26'h0, w} : base + {26'h0, w};
      act       <= 1'b1;
      dal_out   <= {4'hC, wa};
      cs_n_out  <= {1'b1, par({4'hC, wa}) ^ {4{hit && (mode_in == 3'h1 || mode_in == 3'h5)}}};
      // Held until the strobe rises
      rsp_n_out <= {hit && mode_in == 3'h2, !(hit && (mode_in == 3'h2 || mode_in == 3'h3)),
                    hit && mode_in == 3'h5, !(hit && mode_in == 3'h4)};
    end
  end
endmodule

/* tb.sv */
// Bench: reads of every length and response against the responder model.
// Assumes the package, the design and resp_model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb;
  import rd_cycle_pkg::*;
  typedef struct packed {logic [31:0] muxed_addr_data_lines; logic [4:0] st; logic [15:0] bm; logic [7:0] ev;} note_t;
  logic        mclk_in = 1'b0, reset_n_in = 1'b0, vld = 1'b0, lclr = 1'b0, ds_q = 1'b1;
  logic [1:0]  len = 2'h1, bad = 2'h0, dly = 2'h0, widx;
  logic [2:0]  mode = 3'h0, ini = 3'h0;
  logic [27:0] addr = 28'h0;
  logic [15:0] bm = 16'h0;
  logic [4:0]  st = 5'h0, cs_o, cs_m, cs_w;
  logic [31:0] seed = 32'h569E, rdata, dal_o, dal_m, dal_w, xd;
  logic [3:0]  rsp_n, bm_n;
  logic [7:0]  mlog, fl = 8'h0;
  logic        rdy, dv, done, mchk, irq, fill, inval, retry, oe_n, cs_oe_n, wr_n, as_n, ds_n;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, clk_cnt = 0, n_done = 0, wk = 0;
  logic [31:0] dq[$];
  note_t       sq[$];
  logic [19:0] tbl[18] = '{20'h41080, 20'h49041, 20'h69080, 20'h51042, 20'h58004, 20'h58800,
    20'h58400, 20'h81110, 20'hA1088, 20'h89049, 20'h9308A, 20'h9104A, 20'h98004, 20'h9A088,
    20'hC0600, 20'hCC520, 20'hD2482, 20'hD8400};
  assign dal_w = oe_n ? dal_m : dal_o;
  assign cs_w = cs_oe_n ? cs_m : cs_o;
  read_cycle_seq dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_valid_in(vld), .req_ready_out(rdy),
    .req_len_in(len), .req_addr_in(addr), .req_bm_in(bm), .req_status_in(st),
    .req_demand_in(ini[2]), .req_prefetch_in(ini[1]), .req_coproc_in(ini[0]),
    .rd_data_out(rdata), .rd_data_valid_out(dv), .rd_word_idx_out(widx), .done_out(done),
    .mcheck_out(mchk), .coproc_irq_out(irq), .cache_fill_out(fill), .cache_inval_out(inval),
    .retry_out(retry), .memory_error_log_register_out(mlog), .log_clear_in(lclr),
    .muxed_addr_data_lines_out(dal_o), .muxed_addr_data_lines_oe_n_out(oe_n),
    .muxed_addr_data_lines_in(dal_w), .cycle_status_parity_lines_n_out(cs_o),
    .cycle_status_parity_lines_oe_n_out(cs_oe_n), .cycle_status_parity_lines_n_in(cs_w),
    .byte_mask_lines_n_out(bm_n), .wr_n_out(wr_n), .addr_valid_strobe_n_out(as_n),
    .data_strobe_signal_n_out(ds_n), .rdy_n_in(rsp_n[3]), .err_n_in(rsp_n[2]),
    .parity_check_enable_n_in(rsp_n[1]), .cache_inhibit_response_n_in(rsp_n[0]));
  resp_model resp (.clk_in(mclk_in), .oe_n_in(oe_n), .dal_in(dal_w), .ds_n_in(ds_n),
    .mode_in(mode), .bad_in(bad), .dly_in(dly), .dal_out(dal_m), .cs_n_out(cs_m),
    .rsp_n_out(rsp_n));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Row: length, mode, failing word, initiator, expected pulses, expected log
  task automatic run(input logic [19:0] t);
    logic [27:0] a;
    logic [31:0] r;
    int          d0;
    r = rnd();
    a = (t[19:18] == LEN_OCTA) ? {r[27:2], 2'h0} : r[27:0];
    for (int i = 0; i < t[9:7]; i++)
      dq.push_back({4'hC, (t[19:18] == LEN_QUAD) ? a ^ 28'(i) : a + 28'(i)});
    r = rnd();
    sq.push_back({t[19:18], a, 2'h0, r[4:0] | ((t[19:18] == LEN_OCTA) ? 5'h17 : 5'h0),
                  r[31:16], t[9:2]});
    @(negedge mclk_in);
    lclr = 1'b1;
    @(negedge mclk_in);
    {lclr, vld, len, mode, bad, ini, addr, st, bm, dly} = {2'b01, t[19:10], a, r[4:0], r[31:16], r[6:5]};
    d0 = n_done;
    while (rdy !== 1'b1) @(negedge mclk_in);
    @(negedge mclk_in);
    vld = 1'b0;
    while (n_done == d0) @(negedge mclk_in);
    `CHK(mlog[1:0], t[1:0])
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  always @(posedge mclk_in) begin
    clk_cnt++;
    if (vld && rdy) begin
      clk_cnt = 0;
      fl      = 8'h0;
    end
    if (!oe_n) `CHK({dal_o, cs_o, wr_n}, {sq[0].muxed_addr_data_lines, sq[0].st, 1'b1})
    if (!ds_n && ds_q) begin
      `CHK({as_n, bm_n}, {1'b0, ~sq[0].bm[4 * wk +: 4]})
      wk++;
    end
    ds_q = ds_n;
    if (dv) begin
      xd = dq.pop_front();
      `CHK(rdata, xd)
      `CHK(widx, (sq[0].muxed_addr_data_lines[31:30] == LEN_QUAD) ? {1'b0, sq[0].muxed_addr_data_lines[2] ^ fl[5]} : fl[6:5])
      fl[7:5] = fl[7:5] + 3'h1;
    end
    fl[4:0] = fl[4:0] | {mchk, irq, fill, inval, retry};
    if (done) begin
      // Cache pulses only have a defined meaning for quadword fills
      if (sq[0].muxed_addr_data_lines[31:30] != LEN_QUAD) fl[2:1] = 2'h0;
      `CHK(fl, sq[0].ev)
      `CHK(clk_cnt > CLKS_PER_UC * (sq[0].muxed_addr_data_lines[31] ? (sq[0].muxed_addr_data_lines[30] ? MIN_UC_OCTA : MIN_UC_QUAD) : MIN_UC_LONG), 1'b1)
      void'(sq.pop_front());
      fl = 8'h0;
      wk = 0;
      n_done++;
    end
  end
  initial forever #50 mclk_in = ~mclk_in;
  initial begin
    repeat (20) @(negedge mclk_in);
    reset_n_in = 1'b1;
    foreach (tbl[i]) run(tbl[i]);
    wrap_up();
  end
endmodule
